// ===== core/dps_pkg.sv
package dps_pkg;
	// Three-level select codes; 2'b11 is taken as an open (MID) input
	localparam logic [1:0] TRI_LOW  = 2'h0;
	localparam logic [1:0] TRI_MID  = 2'h1;
	localparam logic [1:0] TRI_HIGH = 2'h2;

	// Multiplication factor per range, low-speed and high-speed variant
	localparam logic [7:0] N_LS_LOW  = 8'h40;
	localparam logic [7:0] N_LS_MID  = 8'h20;
	localparam logic [7:0] N_LS_HIGH = 8'h10;
	localparam logic [7:0] N_HS_LOW  = 8'h20;
	localparam logic [7:0] N_HS_MID  = 8'h10;
	localparam logic [7:0] N_HS_HIGH = 8'h08;

	// Common multiple of all divide ratios, sets the alignment frame
	localparam logic [12:0] SUPER_DIVS = 13'h078;
	localparam int          PER_W      = 12;
	localparam int          SUP_W      = 13;
	localparam int          NUM_BANKS  = 5;
	localparam int          FB_BANK    = 4;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_BANK1  = 8'h04;
	localparam logic [7:0] ADDR_BANK4  = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;

	// Control register fields
	localparam int CTRL_FS_LSB  = 0;
	localparam int CTRL_REFSEL  = 2;
	localparam int CTRL_FEEDBACK_OUTPUT_DISABLE   = 3;
	localparam int CTRL_FBF_LSB = 4;
	localparam int CTRL_DS0_LSB = 6;
	localparam int CTRL_DS1_LSB = 8;
	localparam int CTRL_W       = 10;
	localparam logic [CTRL_W-1:0] CTRL_RST = 10'h011;

	// Bank register fields
	localparam int BANK_F0_LSB  = 0;
	localparam int BANK_F1_LSB  = 2;
	localparam int BANK_DS0_LSB = 4;
	localparam int BANK_DS1_LSB = 6;
	localparam int BANK_DIS     = 8;
	localparam int BANK_W       = 9;
	localparam logic [BANK_W-1:0] BANK_RST = 9'h005;

	// Status register fields
	localparam int STAT_N_LSB = 0;
	localparam int STAT_LOCK  = 8;

	// Write and read responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Loop alignment states
	typedef enum logic [1:0] {
		ST_ACQUIRE = 2'h1,
		ST_LOCKED  = 2'h2
	} loop_state_t;
endpackage : dps_pkg

// ===== core/bank_cfg_if.sv
`timescale 1ns/1ns
interface bank_cfg_if;
	logic [11:0]       period;
	logic signed [4:0] skew;
	logic              hold_low;
	logic              advance;
	logic              reload;
	logic              clk_out;
	logic              at_zero;

	modport ctrl (
		output period, skew, hold_low, advance, reload,
		input  clk_out, at_zero
	);
	modport gen (
		input  period, skew, hold_low, advance, reload,
		output clk_out, at_zero
	);
endinterface : bank_cfg_if

// ===== core/bank_phase_gen.sv
`timescale 1ns/1ns
module bank_phase_gen (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Settings and output
	bank_cfg_if.gen  cfg
);
	logic [11:0] cnt_reg;
	logic [11:0] cnt_next;
	logic [11:0] offset;
	logic [11:0] mag;

	assign cfg.at_zero = (cnt_reg == 12'h000);

	// Start count so the rising edge lands skew units after the zero edge
	always_comb begin
		mag = 12'(-cfg.skew);
		if (cfg.skew >= 5'sh00) begin
			offset = (cfg.skew == 5'sh00) ? 12'h000 : cfg.period - 12'(cfg.skew);
		end else begin
			offset = (mag == cfg.period) ? 12'h000 : mag;
		end
	end

	// One count per skew unit, wrapping at the divided period
	always_comb begin
		if (!cfg.advance) begin
			cnt_next = cnt_reg;
		end else if (cfg.reload) begin
			cnt_next = offset;
		end else if (cnt_reg >= cfg.period - 12'h001) begin
			cnt_next = 12'h000;
		end else begin
			cnt_next = cnt_reg + 12'h001;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 12'h000;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// High for the first half of the period, low while disabled
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg.clk_out <= 1'b0;
		end else begin
			cfg.clk_out <= !cfg.hold_low && (cnt_next < (cfg.period >> 1));
		end
	end

	a_hold_low_out: assert property (
		@(posedge clk) disable iff (!arst_n)
		cfg.hold_low |=> !cfg.clk_out
	) else $error("disabled bank still toggles");

	a_reload_place: assert property (
		@(posedge clk) disable iff (!arst_n)
		cfg.advance && cfg.reload |=> cnt_reg == $past(offset)
	) else $error("bank count not placed at skew offset");

	a_unit_wrap: assert property (
		@(posedge clk) disable iff (!arst_n)
		cfg.advance && !cfg.reload && cnt_reg == cfg.period - 12'h001
		|=> cnt_reg == 12'h000
	) else $error("bank period not one unit per count");
endmodule : bank_phase_gen

// ===== core/divide_phase_select_matrix.sv
// Notes on behaviour
// - Changing reference only lengthens output periods; phase is slipped, never advanced.
// - Range select must match the nominal frequency band of the chosen variant.
// - One skew step equals one unit, the nominal period divided by the factor.
// - Factor is 64/32/16 low-speed, 32/16/8 high-speed, for LOW/MID/HIGH.
// - Four output banks, each two pairs, two phase, two divide selects, one disable.
// - Feedback bank drives one output pair; either output may close the loop.
// - Banks 1 and 2 select skews -4 to +4 units over the nine combinations.
// - Banks 3 and 4 give -8,-7,-6, 0, +6,+7,+8 units.
// - Feedback bank phase select gives -4, 0 or +4 units only.
// - Every bank divides by 1,2,3,4,5,6,8,10 or 12 from its pair.
// - Loop aligns feedback rising edge to reference; skews are relative to feedback.
// - Undivided outputs run at nominal frequency, one nominal period per cycle.
// - Three-level select: ground LOW, supply HIGH, open taken as MID.
// - Banks 3 and 4 copy bank 1 skew on MID-LOW, bank 2 on MID-HIGH.
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module divide_phase_select_matrix #(
	parameter logic HIGH_SPEED_VARIANT = 1'b0
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Reference clocks
	input  wire logic        reference_input_a,
	input  wire logic        reference_input_b,
	// Clock outputs
	output logic [15:0]      bank_clock_out,
	output logic [1:0]       feedback_bank_outputs
);
	// Three-level decode, unknown code treated as open
	function automatic logic [1:0] tri_val(input logic [1:0] code);
		case (code)
			dps_pkg::TRI_LOW:  tri_val = 2'h0;
			dps_pkg::TRI_HIGH: tri_val = 2'h2;
			default:           tri_val = 2'h1;
		endcase
	endfunction : tri_val

	// Index 0..8 of a select pair, high select first
	function automatic logic [3:0] pair_idx(input logic [1:0] hi, input logic [1:0] lo);
		pair_idx = 4'({2'h0, tri_val(hi)} * 4'h3) + {2'h0, tri_val(lo)};
	endfunction : pair_idx

	// Banks 1 and 2 skew
	function automatic logic signed [4:0] skew_near(input logic [3:0] idx);
		skew_near = $signed({1'b0, idx}) - 5'sh04;
	endfunction : skew_near

	// Banks 3 and 4 skew, following bank 1 or 2 in the middle row
	function automatic logic signed [4:0] skew_far(input logic [3:0] idx,
		input logic signed [4:0] s1, input logic signed [4:0] s2);
		case (idx)
			4'h0:    skew_far = 5'sh18;
			4'h1:    skew_far = 5'sh19;
			4'h2:    skew_far = 5'sh1a;
			4'h3:    skew_far = s1;
			4'h5:    skew_far = s2;
			4'h6:    skew_far = 5'sh06;
			4'h7:    skew_far = 5'sh07;
			4'h8:    skew_far = 5'sh08;
			default: skew_far = 5'sh00;
		endcase
	endfunction : skew_far

	// Divide ratio of a select pair
	function automatic logic [3:0] div_of(input logic [3:0] idx);
		case (idx)
			4'h6:    div_of = 4'h8;
			4'h7:    div_of = 4'ha;
			4'h8:    div_of = 4'hc;
			default: div_of = idx + 4'h1;
		endcase
	endfunction : div_of

	// Multiplication factor of the selected range
	function automatic logic [7:0] nfac(input logic [1:0] fs);
		case (tri_val(fs))
			2'h0:    nfac = HIGH_SPEED_VARIANT ? dps_pkg::N_HS_LOW : dps_pkg::N_LS_LOW;
			2'h2:    nfac = HIGH_SPEED_VARIANT ? dps_pkg::N_HS_HIGH : dps_pkg::N_LS_HIGH;
			default: nfac = HIGH_SPEED_VARIANT ? dps_pkg::N_HS_MID : dps_pkg::N_LS_MID;
		endcase
	endfunction : nfac

	// Byte-lane merge of a register write
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			wmerge[8*i +: 8] = strb[i] ? data[8*i +: 8] : old[8*i +: 8];
		end
	endfunction : wmerge

	logic [dps_pkg::CTRL_W-1:0] ctrl_reg;
	logic [dps_pkg::BANK_W-1:0] bank_reg [4];
	logic                       aw_got_reg;
	logic                       w_got_reg;
	logic [7:0]                 wa_reg;
	logic [31:0]                wd_reg;
	logic [3:0]                 ws_reg;
	logic                       aw_take;
	logic                       w_take;
	logic                       do_wr;
	logic                       aw_got_next;
	logic                       w_got_next;
	logic                       bvalid_next;
	logic                       ar_take;
	logic                       rvalid_next;
	logic                       wr_hit;
	logic [7:0]                 n_c;
	logic [3:0]                 idx_c [dps_pkg::NUM_BANKS];
	logic [3:0]                 div_c [dps_pkg::NUM_BANKS];
	logic signed [4:0]          skew_c [dps_pkg::NUM_BANKS];
	logic [11:0]                period_c [dps_pkg::NUM_BANKS];
	logic [12:0]                super_reg;
	logic [12:0]                super_lim;
	logic                       ref_now;
	logic                       ref_prev_reg;
	logic                       ref_rise;
	logic                       adv;
	logic                       fb_zero;
	dps_pkg::loop_state_t       state_reg;

	bank_cfg_if bif [dps_pkg::NUM_BANKS] ();

	// Write channel handshakes; address and data may come in either order
	assign aw_take     = awvalid && awready;
	assign w_take      = wvalid && wready;
	assign do_wr       = aw_got_reg && w_got_reg && !bvalid;
	assign aw_got_next = (aw_got_reg || aw_take) && !do_wr;
	assign w_got_next  = (w_got_reg || w_take) && !do_wr;
	assign bvalid_next = do_wr || (bvalid && !bready);
	assign wr_hit      = wa_reg[7:2] <= dps_pkg::ADDR_BANK4[7:2];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_got_reg <= 1'b0;
			w_got_reg  <= 1'b0;
			awready    <= 1'b0;
			wready     <= 1'b0;
			bvalid     <= 1'b0;
			bresp      <= dps_pkg::RESP_OKAY;
		end else begin
			aw_got_reg <= aw_got_next;
			w_got_reg  <= w_got_next;
			awready    <= !aw_got_next && !bvalid_next;
			wready     <= !w_got_next && !bvalid_next;
			bvalid     <= bvalid_next;
			if (do_wr) begin
				bresp <= wr_hit ? dps_pkg::RESP_OKAY : dps_pkg::RESP_SLVERR;
			end
		end
	end

	// Captured write address and data
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wa_reg <= 8'h00;
			wd_reg <= 32'h0000_0000;
			ws_reg <= 4'h0;
		end else begin
			if (aw_take) begin
				wa_reg <= awaddr;
			end
			if (w_take) begin
				wd_reg <= wdata;
				ws_reg <= wstrb;
			end
		end
	end

	// Configuration registers, written once both halves are in
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= dps_pkg::CTRL_RST;
			for (int b = 0; b < 4; b++) begin
				bank_reg[b] <= dps_pkg::BANK_RST;
			end
		end else if (do_wr) begin
			if (wa_reg[7:2] == dps_pkg::ADDR_CTRL[7:2]) begin
				ctrl_reg <= dps_pkg::CTRL_W'(wmerge(32'(ctrl_reg), wd_reg, ws_reg));
			end
			for (int b = 0; b < 4; b++) begin
				if (wa_reg[7:2] == dps_pkg::ADDR_BANK1[7:2] + 6'(b)) begin
					bank_reg[b] <= dps_pkg::BANK_W'(wmerge(32'(bank_reg[b]), wd_reg, ws_reg));
				end
			end
		end
	end

	// Read channel: answer one cycle after the address is taken
	assign ar_take     = arvalid && arready;
	assign rvalid_next = ar_take || (rvalid && !rready);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= dps_pkg::RESP_OKAY;
		end else begin
			arready <= !rvalid_next;
			rvalid  <= rvalid_next;
			if (ar_take) begin
				rresp <= dps_pkg::RESP_OKAY;
				rdata <= 32'h0000_0000;
				if (araddr[7:2] == dps_pkg::ADDR_CTRL[7:2]) begin
					rdata <= 32'(ctrl_reg);
				end else if (araddr[7:2] == dps_pkg::ADDR_STATUS[7:2]) begin
					rdata[dps_pkg::STAT_N_LSB +: 8] <= n_c;
					rdata[dps_pkg::STAT_LOCK]       <= (state_reg == dps_pkg::ST_LOCKED);
				end else if (araddr[7:2] <= dps_pkg::ADDR_BANK4[7:2]) begin
					rdata <= 32'(bank_reg[araddr[3:2] - 2'h1]);
				end else begin
					rresp <= dps_pkg::RESP_SLVERR;
				end
			end
		end
	end

	// Skew and divide per bank from the select pairs
	always_comb begin
		n_c = nfac(ctrl_reg[dps_pkg::CTRL_FS_LSB +: 2]);
		for (int b = 0; b < 4; b++) begin
			idx_c[b] = pair_idx(bank_reg[b][dps_pkg::BANK_F1_LSB +: 2],
				bank_reg[b][dps_pkg::BANK_F0_LSB +: 2]);
			div_c[b] = div_of(pair_idx(bank_reg[b][dps_pkg::BANK_DS1_LSB +: 2],
				bank_reg[b][dps_pkg::BANK_DS0_LSB +: 2]));
		end
		idx_c[4] = {2'h0, tri_val(ctrl_reg[dps_pkg::CTRL_FBF_LSB +: 2])};
		div_c[4] = div_of(pair_idx(ctrl_reg[dps_pkg::CTRL_DS1_LSB +: 2],
			ctrl_reg[dps_pkg::CTRL_DS0_LSB +: 2]));
		skew_c[0] = skew_near(idx_c[0]);
		skew_c[1] = skew_near(idx_c[1]);
		skew_c[2] = skew_far(idx_c[2], skew_c[0], skew_c[1]);
		skew_c[3] = skew_far(idx_c[3], skew_c[0], skew_c[1]);
		skew_c[4] = $signed({1'b0, idx_c[4]}) * 5'sh04 - 5'sh04;
		for (int b = 0; b < dps_pkg::NUM_BANKS; b++) begin
			period_c[b] = 12'({8'h00, div_c[b]} * {4'h0, n_c});
		end
	end

	// Alignment frame: common multiple of all bank periods, in units
	assign super_lim = 13'(dps_pkg::SUPER_DIVS * {5'h00, n_c}) - 13'h0001;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			super_reg <= 13'h0000;
		end else if (adv) begin
			super_reg <= (super_reg >= super_lim) ? 13'h0000 : super_reg + 13'h0001;
		end
	end

	// Selected reference and its rising edge
	assign ref_now  = ctrl_reg[dps_pkg::CTRL_REFSEL] ? reference_input_b : reference_input_a;
	assign ref_rise = ref_now && !ref_prev_reg;
	assign fb_zero  = bif[dps_pkg::FB_BANK].at_zero;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ref_prev_reg <= 1'b0;
		end else begin
			ref_prev_reg <= ref_now;
		end
	end

	// Slip one unit on a misaligned edge; holding only ever lengthens a period
	assign adv = !(ref_rise && !fb_zero);

	// Loop state follows the alignment seen at each reference edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= dps_pkg::ST_ACQUIRE;
		end else begin
			case (state_reg)
				dps_pkg::ST_ACQUIRE: begin
					if (ref_rise && fb_zero) begin
						state_reg <= dps_pkg::ST_LOCKED;
					end
				end
				dps_pkg::ST_LOCKED: begin
					if (ref_rise && !fb_zero) begin
						state_reg <= dps_pkg::ST_ACQUIRE;
					end
				end
				default: state_reg <= dps_pkg::ST_ACQUIRE;
			endcase
		end
	end

	// Five banks, each with its own phase generator
	for (genvar g = 0; g < dps_pkg::NUM_BANKS; g++) begin : g_bank
		assign bif[g].period  = period_c[g];
		assign bif[g].skew    = skew_c[g];
		assign bif[g].advance = adv;
		assign bif[g].reload  = (super_reg == 13'h0000);
		if (g == dps_pkg::FB_BANK) begin : g_fb
			assign bif[g].hold_low = ctrl_reg[dps_pkg::CTRL_FEEDBACK_OUTPUT_DISABLE];
			assign feedback_bank_outputs = {2{bif[g].clk_out}};
		end else begin : g_out
			assign bif[g].hold_low = bank_reg[g][dps_pkg::BANK_DIS];
			assign bank_clock_out[4*g +: 4] = {4{bif[g].clk_out}};
		end
		bank_phase_gen u_gen (
			.clk    (clk),
			.arst_n (arst_n),
			.cfg    (bif[g])
		);
	end

	a_slip_one_unit: assert property (
		@(posedge clk) disable iff (!arst_n)
		!adv |=> adv
	) else $error("phase held for more than one unit");

	a_n_factor: assert property (
		@(posedge clk) disable iff (!arst_n)
		tri_val(ctrl_reg[dps_pkg::CTRL_FS_LSB +: 2]) == 2'h0
		|-> n_c == (HIGH_SPEED_VARIANT ? 8'h20 : 8'h40)
	) else $error("wrong factor for LOW range");

	a_unit_period: assert property (
		@(posedge clk) disable iff (!arst_n)
		div_c[dps_pkg::FB_BANK] == 4'h1 |-> period_c[dps_pkg::FB_BANK] == {4'h0, n_c}
	) else $error("undivided period not factor units");

	a_near_skew: assert property (
		@(posedge clk) disable iff (!arst_n)
		(idx_c[0] != 4'h0 || skew_c[0] == 5'sh1c) && (idx_c[0] != 4'h8 || skew_c[0] == 5'sh04)
	) else $error("bank 1 skew out of table");

	a_far_skew: assert property (
		@(posedge clk) disable iff (!arst_n)
		idx_c[2] == 4'h8 |-> skew_c[2] == 5'sh08
	) else $error("bank 3 skew out of table");

	a_follow_bank: assert property (
		@(posedge clk) disable iff (!arst_n)
		idx_c[3] == 4'h3 |-> skew_c[3] == skew_c[0]
	) else $error("bank 4 does not follow bank 1");

	a_fb_skew_set: assert property (
		@(posedge clk) disable iff (!arst_n)
		skew_c[4] == 5'sh1c || skew_c[4] == 5'sh00 || skew_c[4] == 5'sh04
	) else $error("feedback skew not -4, 0 or +4");

	a_div_twelve: assert property (
		@(posedge clk) disable iff (!arst_n)
		div_c[1] == 4'hc |-> period_c[1] == 12'({8'h00, 4'hc} * {4'h0, n_c})
	) else $error("divide by 12 period wrong");

	a_align_lock: assert property (
		@(posedge clk) disable iff (!arst_n)
		ref_rise && fb_zero |=> state_reg == dps_pkg::ST_LOCKED
	) else $error("aligned edge did not lock");
endmodule : divide_phase_select_matrix

// ===== test/ref_clock_source.sv
`timescale 1ns/1ns
module ref_clock_source (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Reference settings
	input  wire logic [11:0] period,
	input  wire logic [11:0] b_lag,
	// Reference clocks
	output logic             ref_a,
	output logic             ref_b
);
	logic [11:0] cnt_reg;
	logic [11:0] pos_b;

	// Second reference has the same rate and lags the first by b_lag cycles
	assign pos_b = (cnt_reg >= b_lag) ? cnt_reg - b_lag : cnt_reg + period - b_lag;

	// Free-running references, rate set by the period input
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 12'h000;
			ref_a   <= 1'b0;
			ref_b   <= 1'b0;
		end else begin
			cnt_reg <= (cnt_reg + 12'h001 >= period) ? 12'h000 : cnt_reg + 12'h001;
			ref_a   <= cnt_reg < (period >> 1);
			ref_b   <= pos_b < (period >> 1);
		end
	end
endmodule : ref_clock_source

// ===== test/divide_phase_select_matrix_tb_top.sv
`timescale 1ns/1ns
module divide_phase_select_matrix_tb_top;
	logic        clk        = 1'b0;
	logic        arst_n     = 1'b0;
	logic [7:0]  awaddr     = 8'h00;
	logic        awvalid    = 1'b0;
	logic [31:0] wdata      = 32'h0;
	logic [3:0]  wstrb      = 4'hf;
	logic        wvalid     = 1'b0;
	logic        bready     = 1'b0;
	logic [7:0]  araddr     = 8'h00;
	logic        arvalid    = 1'b0;
	logic        rready     = 1'b0;
	logic [11:0] ref_period = 12'h020;
	logic [11:0] b_lag      = 12'h000;
	logic        awready, wready, bvalid, arready, rvalid, ref_a, ref_b;
	logic [1:0]  bresp, rresp, fb_out, r;
	logic [31:0] rdata, d, code;
	logic [15:0] bank_out;
	logic [16:0] taps, prev_taps;
	int          n_errors   = 0;
	int          checks     = 0;
	int          k, j, n, s3;
	int          div_tab [9] = '{1, 2, 3, 4, 5, 6, 8, 10, 12};
	int          sk3_tab [9] = '{-8, -7, -6, 0, 0, 0, 6, 7, 8};
	int          n_tab   [4] = '{64, 32, 16, 32};
	localparam int SETTLE = 120 * 16 + 300;

	// Clock, and the taps watched for edges
	always #4 clk = ~clk;
	assign taps = {fb_out[0], bank_out};

	divide_phase_select_matrix #(.HIGH_SPEED_VARIANT(1'b0)) dut (
		.clk(clk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.reference_input_a(ref_a), .reference_input_b(ref_b),
		.bank_clock_out(bank_out), .feedback_bank_outputs(fb_out)
	);

	ref_clock_source src (
		.clk(clk), .arst_n(arst_n), .period(ref_period), .b_lag(b_lag),
		.ref_a(ref_a), .ref_b(ref_b)
	);

	task final_report;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task hung;
		n_errors++;
		$display("BAD wait expected event seen none");
		final_report();
	endtask : hung

	// Bus write: address and data offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rv);
		int i;
		@(posedge clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= dv;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (i == 100) hung();
		rv = bresp;
		bready <= 1'b0;
	endtask : wr

	// Bus read: request held until taken, data taken with rvalid
	task rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
		int i;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (i == 100) hung();
		dv = rdata;
		rv = rresp;
		rready <= 1'b0;
	endtask : rd

	task wc(input string what, input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er);
		logic [1:0] rv;
		wr(a, dv, rv);
		chk(what, 32'(rv), 32'(er));
	endtask : wc

	task rc(input string what, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] dv;
		logic [1:0]  rv;
		rd(a, dv, rv);
		chk(what, dv, e);
		chk(what, 32'(rv), 32'(er));
	endtask : rc

	function automatic logic up(input int idx);
		return taps[idx] & ~prev_taps[idx];
	endfunction : up

	// Wait for a rising edge on one tap, sampled at the falling clock edge
	task rise(input int idx);
		int i;
		for (i = 0; i < 3000; i++) begin
			@(negedge clk);
			if (up(idx)) break;
		end
		if (i == 3000) hung();
	endtask : rise

	// Cycles from a feedback rising edge to the next rising edge of a tap
	task gap(input int idx, output int cnt);
		rise(16);
		cnt = 0;
		while (!up(idx) && cnt < 1000) begin
			@(negedge clk);
			cnt++;
		end
		if (cnt == 1000) hung();
	endtask : gap

	// Cycles between two rising edges of a tap
	task per(input int idx, output int cnt);
		rise(idx);
		cnt = 0;
		do begin
			@(negedge clk);
			cnt++;
		end while (!up(idx) && cnt < 3000);
		if (cnt == 3000) hung();
	endtask : per

	task settle;
		repeat (SETTLE) @(posedge clk);
	endtask : settle

	// Edge history and the pairing of identical outputs
	always @(negedge clk) begin
		prev_taps <= taps;
		if (arst_n) begin
			chk("fb_pair", 32'(fb_out[1]), 32'(fb_out[0]));
			for (int b = 0; b < 4; b++) chk("copies", 32'(bank_out[4*b+:4] inside {4'h0, 4'hf}), 1);
		end
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rc("ctrl_rst", dps_pkg::ADDR_CTRL, 32'h011, dps_pkg::RESP_OKAY);
		for (k = 0; k < 4; k++) rc("bank_rst", 8'h04 + 8'(4 * k), 32'h005, dps_pkg::RESP_OKAY);
		for (k = 0; k < 4; k++) begin
			wc("ctrl_wr", dps_pkg::ADDR_CTRL, 32'h010 | 32'(k), dps_pkg::RESP_OKAY);
			rd(dps_pkg::ADDR_STATUS, d, r);
			chk("factor", d & 32'h0ff, 32'(n_tab[k]));
		end
		wc("stat_wr", dps_pkg::ADDR_STATUS, 32'h0, dps_pkg::RESP_SLVERR);
		wc("hole_wr", 8'h18, 32'h0, dps_pkg::RESP_SLVERR);
		rc("hole_rd", 8'h18, 32'h0, dps_pkg::RESP_SLVERR);
		ref_period <= 12'h010;
		wc("ctrl_wr", dps_pkg::ADDR_CTRL, 32'h012, dps_pkg::RESP_OKAY);
		wc("bank2_wr", 8'h08, 32'h002, dps_pkg::RESP_OKAY);
		// Every phase code on banks 1, 3 and 4, with bank 2 held at -2
		for (k = 0; k < 9; k++) begin
			code = 32'(((k / 3) << 2) | (k % 3));
			for (j = 0; j < 4; j += (j == 0) ? 2 : 1) wc("bank_wr", 8'h04 + 8'(4 * j), code, 2'h0);
			settle();
			s3 = (k == 3) ? -1 : (k == 5) ? -2 : sk3_tab[k];
			gap(0, n);
			chk("skew_b1", 32'(n), 32'((k - 4) & 15));
			gap(8, n);
			chk("skew_b3", 32'(n), 32'(s3 & 15));
			gap(12, n);
			chk("skew_b4", 32'(n), 32'(s3 & 15));
		end
		// Feedback phase LOW and HIGH shift the matrix, checked on bank 1 only
		for (k = 0; k < 3; k += 2) begin
			wc("ctrl_wr", dps_pkg::ADDR_CTRL, 32'h002 | 32'(k << 4), dps_pkg::RESP_OKAY);
			settle();
			gap(0, n);
			chk("rel_b1", 32'(n), 32'((8 - 4 * k) & 15));
		end
		rc("locked", dps_pkg::ADDR_STATUS, 32'h110, dps_pkg::RESP_OKAY);
		wc("ctrl_wr", dps_pkg::ADDR_CTRL, 32'h012, dps_pkg::RESP_OKAY);
		// Every divide code on all four banks, checked on banks 1 and 4 only
		for (k = 0; k < 9; k++) begin
			code = 32'(((k / 3) << 6) | ((k % 3) << 4) | 5);
			for (j = 0; j < 4; j++) wc("bank_wr", 8'h04 + 8'(4 * j), code, dps_pkg::RESP_OKAY);
			settle();
			per(0, n);
			chk("div_b1", 32'(n), 32'(div_tab[k] * 16));
			per(12, n);
			chk("div_b4", 32'(n), 32'(div_tab[k] * 16));
		end
		for (j = 0; j < 4; j++) wc("bank_wr", 8'h04 + 8'(4 * j), 32'h005, dps_pkg::RESP_OKAY);
		b_lag <= 12'h005;
		settle();
		// Switch to the lagging reference; no bank 1 period may shorten
		wc("ctrl_wr", dps_pkg::ADDR_CTRL, 32'h016, dps_pkg::RESP_OKAY);
		for (k = 0; k < 60; k++) begin
			per(0, n);
			chk("min_period", 32'(n >= 16), 1);
		end
		rc("relocked", dps_pkg::ADDR_STATUS, 32'h110, dps_pkg::RESP_OKAY);
		// Bank 2 and feedback bank disabled, held low
		wc("bank2_wr", 8'h08, 32'h105, dps_pkg::RESP_OKAY);
		wc("ctrl_wr", dps_pkg::ADDR_CTRL, 32'h01e, dps_pkg::RESP_OKAY);
		repeat (2) @(posedge clk);
		for (k = 0; k < 40; k++) begin
			@(negedge clk);
			chk("disabled", 32'({bank_out[7:4], fb_out}), 0);
		end
		final_report();
	end
endmodule : divide_phase_select_matrix_tb_top
